// ### hw/stem_core.sv
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Lane synchronization enable follows link control bit 4.
// (RULE2) Timestamp LSB mode replaces sample LSB with captured reference edge.
// (RULE3) Control bits only in two, four, eight lane modes; none in six.
// (RULE4) Six lane carries 12-bit samples, other modes 16-bit samples.
// (RULE5) Six lane mode powers down the two unused lanes.
// (RULE6) Control bit field: 00 none, 01 overrange, 10 overrange plus timestamp.
// (RULE7) With two control bits, timestamp bit marks sample at reference rise.
// (RULE8) Reference edge inside default setup or hold window raises a flag.
// (RULE9) Flags readable in status and drivable onto interrupt pin by mask.
// (RULE10) Setup guardband 3-bit field widens setup window by up to seven steps.
// (RULE11) Hold guardband 3-bit field widens hold window by up to seven steps.
// (RULE12) Guardband 000 adds nothing; only actual window flags.
// (RULE13) Setup flag at status bit 2, hold flag at status bit 3.
// (RULE14) Setup mask at mask bit 2, hold mask at mask bit 3.
// (RULE15) Flags are sticky until software clears them.
// (RULE16) Clear bit set clears and holds both flags at zero.
// (RULE17) Edge only in setup guardband sets only the setup flag.
// (RULE18) Edge only in hold guardband sets only the hold flag.
// (RULE19) Source should place its edge ahead of both windows.
// (RULE20) Capture edge select: 0 rising, 1 falling clock edge.
// (RULE21) Exactly one sample is timestamped per captured reference rise.
module stem_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire stem_pkg::stem_bus_type bus,
  output logic [7:0] rd_data,
  input wire stem_pkg::stem_sample_in_type sample_in,
  output stem_pkg::stem_sample_out_type sample_out,
  input wire logic sysref_pin,
  input wire logic [stem_pkg::TAPS-1:0] setup_hit,
  input wire logic [stem_pkg::TAPS-1:0] hold_hit,
  output logic irq,
  output logic lane_sync_en,
  output logic [stem_pkg::LANES-1:0] lane_power
);

  logic [7:0] rd_data_r;
  logic ts_lsb_r;
  logic flag_clr_r;
  logic cap_fall_r;
  logic lane_sync_r;
  stem_pkg::stem_cs_type cs_r;
  logic [2:0] hold_guard_r;
  logic [2:0] setup_guard_r;
  logic [1:0] mask_r;
  stem_pkg::stem_lane_type lane_mode_r;
  logic [1:0] flags_r;
  logic [1:0] flags_nxt;
  logic irq_r;
  logic lane_sync_en_r;
  logic [stem_pkg::LANES-1:0] lane_power_r;
  stem_pkg::stem_sample_out_type sample_out_r;

  function automatic logic hit_write(input stem_pkg::stem_bus_type b,
                                     input logic [8:0] a);
    hit_write = b.wr && (b.addr == a);
  endfunction

  // Register writes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ts_lsb_r <= 1'b0;
      flag_clr_r <= 1'b0;
      cap_fall_r <= 1'b0;
      lane_sync_r <= 1'b0;
      cs_r <= stem_pkg::STEM_CS_NONE;
      hold_guard_r <= 3'h0;
      setup_guard_r <= 3'h0;
      mask_r <= 2'h0;
      lane_mode_r <= stem_pkg::stem_lane_type'(stem_pkg::RST_LANE_MODE);
    end
    else
    begin
      if (hit_write(bus, stem_pkg::ADDR_SYSREF_CTL))
      begin
        ts_lsb_r <= bus.wdata[stem_pkg::BIT_TS_LSB];
        flag_clr_r <= bus.wdata[stem_pkg::BIT_FLAG_CLR];
        cap_fall_r <= bus.wdata[stem_pkg::BIT_CAP_FALL];
      end
      if (hit_write(bus, stem_pkg::ADDR_LINK_CTL))
        lane_sync_r <= bus.wdata[stem_pkg::BIT_LANE_SYNC];
      if (hit_write(bus, stem_pkg::ADDR_CTRL_BITS))
        cs_r <= stem_pkg::stem_cs_type'(bus.wdata[stem_pkg::CS_HI:stem_pkg::CS_LO]);
      if (hit_write(bus, stem_pkg::ADDR_HOLD_GUARD))
        hold_guard_r <= bus.wdata[stem_pkg::GUARD_HI:stem_pkg::GUARD_LO]; // [RULE11]
      if (hit_write(bus, stem_pkg::ADDR_SETUP_GUARD))
        setup_guard_r <= bus.wdata[stem_pkg::GUARD_HI:stem_pkg::GUARD_LO]; // [RULE10]
      if (hit_write(bus, stem_pkg::ADDR_IRQ_MASK))
        mask_r <= bus.wdata[stem_pkg::BIT_HOLD:stem_pkg::BIT_SETUP]; // [RULE14]
      if (hit_write(bus, stem_pkg::ADDR_LANE_MODE))
        lane_mode_r <= stem_pkg::stem_lane_type'(bus.wdata[stem_pkg::LANE_HI:0]);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data_r <= stem_pkg::RST_BYTE;
    else if (!bus.rd)
      rd_data_r <= stem_pkg::RST_BYTE;
    else
    begin
      rd_data_r <= stem_pkg::RST_BYTE;
      case (bus.addr)
        stem_pkg::ADDR_SYSREF_CTL:
          rd_data_r <= {ts_lsb_r, flag_clr_r, 2'h0, cap_fall_r, 3'h0};
        stem_pkg::ADDR_LINK_CTL:
          rd_data_r <= {3'h0, lane_sync_r, 4'h0};
        stem_pkg::ADDR_CTRL_BITS:
          rd_data_r <= {cs_r, 6'h00};
        stem_pkg::ADDR_IRQ_STATUS:
          rd_data_r <= {4'h0, flags_r, 2'h0}; // [RULE9] [RULE13]
        stem_pkg::ADDR_IRQ_MASK:
          rd_data_r <= {4'h0, mask_r, 2'h0};
        stem_pkg::ADDR_HOLD_GUARD:
          rd_data_r <= {hold_guard_r, 5'h00};
        stem_pkg::ADDR_SETUP_GUARD:
          rd_data_r <= {setup_guard_r, 5'h00};
        stem_pkg::ADDR_LANE_MODE:
          rd_data_r <= {6'h00, lane_mode_r};
        default:
          rd_data_r <= stem_pkg::RST_BYTE;
      endcase
    end
  end

  // Reference capture edge; analog sampling stays on the rising edge
  logic sysref_fall_r;
  always_ff @(negedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sysref_fall_r <= 1'b0;
    else
      sysref_fall_r <= sysref_pin;
  end

  logic [2:0] sref_sync_r;
  logic sref_stable_r;
  logic sref_rise;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sref_sync_r <= 3'h0;
    else
      sref_sync_r <= {sref_sync_r[1:0], cap_fall_r ? sysref_fall_r : sysref_pin}; // [RULE20]
  end

  // A level counts only once stages two and three agree
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sref_stable_r <= 1'b0;
    else if (sref_sync_r[1] == sref_sync_r[2])
      sref_stable_r <= sref_sync_r[2];
  end

  assign sref_rise = (sref_sync_r[1] == sref_sync_r[2]) && sref_sync_r[2] && !sref_stable_r;

  // Window tap vectors come from the analog delay line, so they are resynchronised
  logic [stem_pkg::TAPS-1:0] su_s1_r, su_s2_r, su_s3_r, su_st_r;
  logic [stem_pkg::TAPS-1:0] ho_s1_r, ho_s2_r, ho_s3_r, ho_st_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      su_s1_r <= '0;
      su_s2_r <= '0;
      su_s3_r <= '0;
      ho_s1_r <= '0;
      ho_s2_r <= '0;
      ho_s3_r <= '0;
    end
    else
    begin
      su_s1_r <= setup_hit;
      su_s2_r <= su_s1_r;
      su_s3_r <= su_s2_r;
      ho_s1_r <= hold_hit;
      ho_s2_r <= ho_s1_r;
      ho_s3_r <= ho_s2_r;
    end
  end

  genvar k;
  generate
    for (k = 0; k < stem_pkg::TAPS; k++)
    begin : g_tap
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          su_st_r[k] <= 1'b0;
          ho_st_r[k] <= 1'b0;
        end
        else
        begin
          if (su_s2_r[k] == su_s3_r[k])
            su_st_r[k] <= su_s3_r[k];
          if (ho_s2_r[k] == ho_s3_r[k])
            ho_st_r[k] <= ho_s3_r[k];
        end
      end
    end
  endgenerate

  // Each window checks only its own tap, so one side never sets the other
  logic setup_event;
  logic hold_event;
  assign setup_event = sref_rise && su_st_r[setup_guard_r]; // [RULE8] [RULE10] [RULE12] [RULE17]
  assign hold_event = sref_rise && ho_st_r[hold_guard_r]; // [RULE8] [RULE11] [RULE12] [RULE18]

  // Clear bit is a held clear, so here it outranks new events
  always_comb
  begin
    flags_nxt = flags_r | {hold_event, setup_event}; // [RULE15]
    if (flag_clr_r)
      flags_nxt = 2'h0; // [RULE16]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_r <= 2'h0;
    else
      flags_r <= flags_nxt;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(flags_nxt & mask_r); // [RULE9]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lane_sync_en_r <= 1'b0;
      lane_power_r <= stem_pkg::LANES_EIGHT;
    end
    else
    begin
      lane_sync_en_r <= lane_sync_r; // [RULE1]
      case (lane_mode_r)
        stem_pkg::STEM_LANE_TWO: lane_power_r <= stem_pkg::LANES_TWO;
        stem_pkg::STEM_LANE_FOUR: lane_power_r <= stem_pkg::LANES_FOUR;
        stem_pkg::STEM_LANE_SIX: lane_power_r <= stem_pkg::LANES_SIX; // [RULE5]
        default: lane_power_r <= stem_pkg::LANES_EIGHT;
      endcase
    end
  end

  // Timestamp waits for the next sample if the rise comes between samples
  logic ts_pend_r;
  logic ts_now;
  assign ts_now = ts_pend_r || sref_rise;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ts_pend_r <= 1'b0;
    else if (sample_in.valid)
      ts_pend_r <= 1'b0; // [RULE21]
    else
      ts_pend_r <= ts_now;
  end

  logic [stem_pkg::RAW_W-1:0] raw;
  logic [1:0] ctl;
  always_comb
  begin
    raw = sample_in.data;
    if (ts_lsb_r)
      raw[0] = ts_now; // [RULE2]
    case (cs_r)
      stem_pkg::STEM_CS_OVR: ctl = {sample_in.overrange, 1'b0}; // [RULE6]
      stem_pkg::STEM_CS_OVR_TS: ctl = {sample_in.overrange, ts_now}; // [RULE6] [RULE7]
      default: ctl = 2'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sample_out_r <= '0;
    else
    begin
      sample_out_r.valid <= sample_in.valid;
      if (lane_mode_r == stem_pkg::STEM_LANE_SIX)
        sample_out_r.data <= {4'h0, raw}; // [RULE3] [RULE4]
      else
        sample_out_r.data <= {raw, ctl, 2'h0}; // [RULE4]
    end
  end

  assign rd_data = rd_data_r;
  assign irq = irq_r;
  assign lane_sync_en = lane_sync_en_r;
  assign lane_power = lane_power_r;
  assign sample_out = sample_out_r;

endmodule // stem_core

// ### hw/stem_pkg.sv
package stem_pkg;

  localparam logic [8:0] ADDR_SYSREF_CTL = 9'h03a;
  localparam logic [8:0] ADDR_LINK_CTL = 9'h05f;
  localparam logic [8:0] ADDR_CTRL_BITS = 9'h072;
  localparam logic [8:0] ADDR_IRQ_STATUS = 9'h100;
  localparam logic [8:0] ADDR_IRQ_MASK = 9'h101;
  localparam logic [8:0] ADDR_HOLD_GUARD = 9'h13b;
  localparam logic [8:0] ADDR_SETUP_GUARD = 9'h13c;
  localparam logic [8:0] ADDR_LANE_MODE = 9'h0a0;

  localparam int BIT_TS_LSB = 7;
  localparam int BIT_FLAG_CLR = 6;
  localparam int BIT_CAP_FALL = 3;
  localparam int BIT_LANE_SYNC = 4;
  localparam int CS_HI = 7;
  localparam int CS_LO = 6;
  localparam int GUARD_HI = 7;
  localparam int GUARD_LO = 5;
  localparam int BIT_SETUP = 2;
  localparam int BIT_HOLD = 3;
  localparam int LANE_HI = 1;

  localparam int RAW_W = 12;
  localparam int OUT_W = 16;
  localparam int TAPS = 8;
  localparam int LANES = 8;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_LANE_MODE = 2'h3;
  localparam logic [7:0] LANES_TWO = 8'h03;
  localparam logic [7:0] LANES_FOUR = 8'h0f;
  localparam logic [7:0] LANES_SIX = 8'h3f;
  localparam logic [7:0] LANES_EIGHT = 8'hff;

  typedef enum logic [1:0] {
    STEM_CS_NONE,
    STEM_CS_OVR,
    STEM_CS_OVR_TS,
    STEM_CS_RSVD
  } stem_cs_type;

  typedef enum logic [1:0] {
    STEM_LANE_TWO,
    STEM_LANE_FOUR,
    STEM_LANE_SIX,
    STEM_LANE_EIGHT
  } stem_lane_type;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stem_bus_type;

  typedef struct packed {
    logic valid;
    logic overrange;
    logic [RAW_W-1:0] data;
  } stem_sample_in_type;

  typedef struct packed {
    logic valid;
    logic [OUT_W-1:0] data;
  } stem_sample_out_type;

endpackage

// ### tb/stem_core_asserts.sv
`timescale 1ns/10ps
module stem_core_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire stem_pkg::stem_bus_type bus,
  input wire logic [7:0] rd_data,
  input wire stem_pkg::stem_sample_in_type sample_in,
  input wire stem_pkg::stem_sample_out_type sample_out,
  input wire logic sysref_pin,
  input wire logic [7:0] setup_hit,
  input wire logic [7:0] hold_hit,
  input wire logic irq,
  input wire logic lane_sync_en,
  input wire logic [7:0] lane_power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence quiet(a);
    !(bus.wr && bus.addr == a);
  endsequence
  sequence sync_wr;
    bus.wr && bus.addr == stem_pkg::ADDR_LINK_CTL;
  endsequence
  sequence six_wr;
    bus.wr && bus.addr == stem_pkg::ADDR_LANE_MODE && bus.wdata[1:0] == 2'h2;
  endsequence
  sequence mask_off;
    bus.wr && bus.addr == stem_pkg::ADDR_IRQ_MASK && bus.wdata[3:2] == 2'h0;
  endsequence
  a_rd_idle: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
    else $error("Read data not idle");
  a_status_bits: assert property (bus.rd && bus.addr == stem_pkg::ADDR_IRQ_STATUS
    |=> rd_data[7:4] == 4'h0 && rd_data[1:0] == 2'h0) else $error("Stray status bits");
  a_out_valid: assert property (sample_in.valid |=> sample_out.valid)
    else $error("Sample lost");
  a_six_no_ctrl: assert property (lane_power == 8'h3f && $past(lane_power) == 8'h3f
    |-> sample_out.data[15:12] == 4'h0) else $error("Six lane sample too wide");
  a_pad_zero: assert property (lane_power != 8'h3f && $past(lane_power) != 8'h3f
    |-> sample_out.data[1:0] == 2'h0) else $error("Pad bits not zero");
  a_clear_irq: assert property (bus.wr && bus.addr == stem_pkg::ADDR_SYSREF_CTL
    && bus.wdata[6] |-> ##2 !irq) else $error("Clear left irq high");
  a_mask_off: assert property (mask_off |-> ##2 !irq)
    else $error("Masked irq still high");
  a_sync_copy: assert property (sync_wr ##1 quiet(stem_pkg::ADDR_LINK_CTL)
    |-> ##1 lane_sync_en == $past(bus.wdata[4], 2)) else $error("Lane sync mismatch");
  a_lane_six: assert property (six_wr ##1 quiet(stem_pkg::ADDR_LANE_MODE)
    |-> ##1 lane_power == stem_pkg::LANES_SIX) else $error("Six lane power wrong");
endmodule // stem_core_asserts
bind stem_core stem_core_asserts u_chk (.clk(clk), .reset_n(reset_n), .bus(bus),
  .rd_data(rd_data), .sample_in(sample_in), .sample_out(sample_out), .sysref_pin(sysref_pin),
  .setup_hit(setup_hit), .hold_hit(hold_hit), .irq(irq), .lane_sync_en(lane_sync_en),
  .lane_power(lane_power));

// ### tb/stem_rx_model.sv
`timescale 1ns/10ps
module stem_rx_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire stem_pkg::stem_sample_out_type rx,
  output int ts_cnt
);
  // Counts marked samples; meaningful only with two control bits
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      ts_cnt <= 0;
    else if (rx.valid && rx.data[2])
      ts_cnt <= ts_cnt + 1;
endmodule // stem_rx_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  stem_pkg::stem_bus_type bus = '0;
  stem_pkg::stem_sample_in_type sample_in = '0;
  logic sysref_pin = 1'b0;
  logic [7:0] setup_hit = 8'h00;
  logic [7:0] hold_hit = 8'h00;
  logic [7:0] rd_data;
  stem_pkg::stem_sample_out_type sample_out;
  logic irq;
  logic lane_sync_en;
  logic [7:0] lane_power;
  int ts_cnt;
  int n_fail = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  stem_core dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rd_data(rd_data),
    .sample_in(sample_in), .sample_out(sample_out), .sysref_pin(sysref_pin),
    .setup_hit(setup_hit), .hold_hit(hold_hit), .irq(irq), .lane_sync_en(lane_sync_en),
    .lane_power(lane_power));
  stem_rx_model rx (.clk(clk), .reset_n(reset_n), .rx(sample_out), .ts_cnt(ts_cnt));
  task automatic end_sim;
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [8:0] a, logic [7:0] exp);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 cmp({8'h00, rd_data}, {8'h00, exp});
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Long low phase lets the synchronised hit vectors agree first
  task automatic sref;
    @(posedge clk) sysref_pin <= 1'b0;
    repeat (5) @(posedge clk);
    sysref_pin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    sample_in <= '{1'b1, 1'b1, 12'habd};
    rd(9'h0a0, 8'h03);
    cmp({8'h00, lane_power}, 16'h00ff);
    wr(9'h05f, 8'h10);
    settle;
    cmp({15'h0, lane_sync_en}, 16'h0001);
    wr(9'h05f, 8'h00);
    settle;
    cmp({15'h0, lane_sync_en}, 16'h0000);
    for (int c = 0; c < 3; c++)
    begin
      wr(9'h072, 8'(c << 6));
      settle;
      cmp(sample_out.data, {12'habd, 1'(c != 0), 3'h0});
    end
    sref;
    cmp(16'(ts_cnt), 16'h0001);
    wr(9'h03a, 8'h08);
    sref;
    cmp(16'(ts_cnt), 16'h0002);
    wr(9'h03a, 8'h80);
    settle;
    cmp(sample_out.data, {12'habc, 4'h8});
    wr(9'h0a0, 8'h02);
    settle;
    cmp({8'h00, lane_power}, 16'h003f);
    cmp(sample_out.data, {4'h0, 12'habc});
    wr(9'h0a0, 8'h00);
    settle;
    cmp({8'h00, lane_power}, 16'h0003);
    wr(9'h0a0, 8'h01);
    settle;
    cmp({8'h00, lane_power}, 16'h000f);
    wr(9'h03a, 8'h00);
    wr(9'h0a0, 8'h03);
    wr(9'h101, 8'h0c);
    for (int k = 0; k < 2; k++)
      for (int g = 0; g < 8; g++)
      begin
        setup_hit <= k ? 8'h00 : 8'hf0;
        hold_hit <= k ? 8'hf0 : 8'h00;
        wr(9'h03a, 8'h40);
        wr(9'h03a, 8'h00);
        wr(k ? 9'h13b : 9'h13c, 8'(g << 5));
        sref;
        rd(9'h100, g > 3 ? (k ? 8'h08 : 8'h04) : 8'h00);
        cmp({15'h0, irq}, 16'(g > 3));
      end
    wr(9'h13b, 8'h00);
    wr(9'h13c, 8'h00);
    setup_hit <= 8'h01;
    hold_hit <= 8'h00;
    wr(9'h03a, 8'h40);
    wr(9'h03a, 8'h00);
    sref;
    rd(9'h100, 8'h04);
    setup_hit <= 8'h00;
    sref;
    rd(9'h100, 8'h04);
    wr(9'h101, 8'h08);
    settle;
    cmp({15'h0, irq}, 16'h0000);
    wr(9'h03a, 8'h40);
    setup_hit <= 8'h01;
    sref;
    rd(9'h100, 8'h00);
    wr(9'h03a, 8'h00);
    wr(9'h101, 8'h00);
    rd(9'h1ff, 8'h00);
    end_sim;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule // tb_top
